/* flash_ctl_defs.svh */
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH

// ------------------------------------------------------------
// software registers of the controller
// ------------------------------------------------------------
`define REG_CMD 4'h0
`define REG_ADDR 4'h1
`define REG_DATA 4'h2
`define REG_STATUS 4'h3
`define REG_RDATA 4'h4
`define REG_POLLS 4'h5
`define REG_RDATA_RESET 16'h0000

// command codes written to REG_CMD
`define OP_READ 4'h1
`define OP_RESET 4'h2
`define OP_IDENT 4'h3
`define OP_PROGRAM 4'h4
`define OP_ERASE 4'h5

// ------------------------------------------------------------
// device command words and unlock addresses
// ------------------------------------------------------------
`define UNLOCK_ADDR1 16'h0555
`define UNLOCK_ADDR2 16'h02aa
`define UNLOCK_DATA1 16'h00aa
`define UNLOCK_DATA2 16'h0055
`define CMD_READ_RESET 16'h00f0
`define CMD_IDENTIFY 16'h0090
`define CMD_WORD_WRITE 16'h00a0
`define CMD_ERASE_SETUP 16'h0080
`define CMD_ERASE_CONFIRM 16'h0010

// ------------------------------------------------------------
// device status bit positions
// ------------------------------------------------------------
`define ST_POLL_BIT 7
`define ST_TOGGLE_BIT 6
`define ST_FAIL_BIT 5
`define ST_TIMER_BIT 3
`define ST_ERASE_TOGGLE_BIT 2
`define ST_VALID_MASK 16'h00ec

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_MHZ 20
`define RESET_WAIT_US 10
`define RESET_WAIT_CYC (`RESET_WAIT_US * `CLK_MHZ)
// strobe phase length in clock cycles
`define PHASE_CYC 4'h2

`endif

/* flash_ctl_pkg.sv */
package flash_ctl_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] dout;
    logic dout_en;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } flash_pins_s;

  typedef struct packed {
    logic we;
    logic re;
    logic [3:0] addr;
    logic [15:0] wdata;
  } sw_req_s;

  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_SETUP,
    CYC_STROBE,
    CYC_HOLD,
    CYC_DONE
  } cycle_state_e;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_WRITE,
    SEQ_READ,
    SEQ_POLL,
    SEQ_WAIT,
    SEQ_FINISH
  } seq_state_e;

endpackage

/* flash_bus_cycle.sv */
`timescale 1ns/10ps
`include "flash_ctl_defs.svh"

// one read or write cycle on the flash pins, framed by setup and hold phases
module flash_bus_cycle (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] i_din,
  output flash_ctl_pkg::flash_pins_s o_pins,
  output logic [15:0] o_rdata,
  output logic o_done
);

  flash_ctl_pkg::cycle_state_e state;
  logic [3:0] cnt;
  logic wr;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= flash_ctl_pkg::CYC_IDLE;
      cnt <= 4'h0;
      wr <= 1'b0;
    end else begin
      case (state)
        flash_ctl_pkg::CYC_IDLE: begin
          if (i_start) begin
            wr <= i_write;
            cnt <= `PHASE_CYC;
            state <= flash_ctl_pkg::CYC_SETUP;
          end
        end
        flash_ctl_pkg::CYC_SETUP,
        flash_ctl_pkg::CYC_STROBE,
        flash_ctl_pkg::CYC_HOLD: begin
          if (cnt == 4'h1) begin
            cnt <= `PHASE_CYC;
            if (state == flash_ctl_pkg::CYC_SETUP) begin
              state <= flash_ctl_pkg::CYC_STROBE;
            end else if (state == flash_ctl_pkg::CYC_STROBE) begin
              state <= flash_ctl_pkg::CYC_HOLD;
            end else begin
              state <= flash_ctl_pkg::CYC_DONE;
            end
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        flash_ctl_pkg::CYC_DONE: state <= flash_ctl_pkg::CYC_IDLE;
        default: state <= flash_ctl_pkg::CYC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  // address and data held stable across the whole strobe, so the device
  // latches address on the falling and data on the rising edge
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pins <= '{addr: 16'h0000, dout: 16'h0000, dout_en: 1'b0,
                  ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else if (state == flash_ctl_pkg::CYC_IDLE && i_start) begin
      o_pins.addr <= i_addr;
      o_pins.dout <= i_wdata;
      o_pins.dout_en <= i_write;
      o_pins.ce_n <= 1'b0;
    end else if (state == flash_ctl_pkg::CYC_SETUP && cnt == 4'h1) begin
      o_pins.we_n <= !wr;
      o_pins.oe_n <= wr;
    end else if (state == flash_ctl_pkg::CYC_STROBE && cnt == 4'h1) begin
      o_pins.we_n <= 1'b1;
      o_pins.oe_n <= 1'b1;
    end else if (state == flash_ctl_pkg::CYC_HOLD && cnt == 4'h1) begin
      o_pins.ce_n <= 1'b1;
      o_pins.dout_en <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 16'h0000;
      o_done <= 1'b0;
    end else begin
      o_done <= (state == flash_ctl_pkg::CYC_HOLD) && (cnt == 4'h1);
      if (state == flash_ctl_pkg::CYC_STROBE && cnt == 4'h1 && !wr) begin
        o_rdata <= i_din;
      end
    end
  end

endmodule // flash_bus_cycle

/* flash_command_status_unit.sv */
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`include "flash_ctl_defs.svh"

// What this block does
// - wait 10us after reset from program/erase
// - unlock pair AAh@555h then 55h@2AAh
// - unlock in cycles 1-2, erase also 4-5
// - program: unlock, A0h@555h, address/data write
// - erase: unlock, 80h, unlock, 10h@555h
// - host masks reserved status bits 0,1,4
module flash_command_status_unit (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  input wire logic [15:0] i_flash_din,
  output logic [15:0] o_flash_addr,
  output logic [15:0] o_flash_dout,
  output logic o_flash_dout_en,
  output logic o_flash_ce_n,
  output logic o_flash_oe_n,
  output logic o_flash_we_n
);

  flash_ctl_pkg::seq_state_e state;
  flash_ctl_pkg::flash_pins_s pins;
  logic [15:0] cyc_rdata;
  logic cyc_done;
  logic cyc_start;
  logic cyc_write;
  logic [15:0] cyc_addr;
  logic [15:0] cyc_wdata;
  logic [3:0] op;
  logic [15:0] tgt_addr;
  logic [15:0] tgt_data;
  logic [2:0] step;
  logic [2:0] nsteps;
  logic [15:0] last_read;
  logic [15:0] result;
  logic [15:0] polls;
  logic busy;
  logic failed;
  logic done;
  logic [15:0] wait_cnt;

  flash_bus_cycle u_cycle (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(cyc_start),
    .i_write(cyc_write),
    .i_addr(cyc_addr),
    .i_wdata(cyc_wdata),
    .i_din(i_flash_din),
    .o_pins(pins),
    .o_rdata(cyc_rdata),
    .o_done(cyc_done)
  );

  // ------------------------------------------------------------
  // write sequence table
  // ------------------------------------------------------------
  // unlocks always use the full 555h/2AAh addresses; the device only
  // compares bits 0..10, so upper bits zero is always safe
  always_comb begin
    cyc_write = 1'b1;
    cyc_addr = `UNLOCK_ADDR1;
    cyc_wdata = `UNLOCK_DATA1;
    case (step)
      3'h0: cyc_wdata = `UNLOCK_DATA1;
      3'h1: begin
        cyc_addr = `UNLOCK_ADDR2;
        cyc_wdata = `UNLOCK_DATA2;
      end
      3'h2: begin
        case (op)
          `OP_IDENT: cyc_wdata = `CMD_IDENTIFY;
          `OP_PROGRAM: cyc_wdata = `CMD_WORD_WRITE;
          `OP_ERASE: cyc_wdata = `CMD_ERASE_SETUP;
          default: cyc_wdata = `CMD_READ_RESET;
        endcase
      end
      3'h3: begin
        if (op == `OP_PROGRAM) begin
          cyc_addr = tgt_addr;
          cyc_wdata = tgt_data;
        end
      end
      3'h4: begin
        cyc_addr = `UNLOCK_ADDR2;
        cyc_wdata = `UNLOCK_DATA2;
      end
      3'h5: cyc_wdata = `CMD_ERASE_CONFIRM;
      default: cyc_wdata = `CMD_READ_RESET;
    endcase
    if (state != flash_ctl_pkg::SEQ_WRITE) begin
      cyc_write = 1'b0;
      cyc_addr = tgt_addr;
    end
  end

  assign cyc_start = (state == flash_ctl_pkg::SEQ_WRITE ||
                      state == flash_ctl_pkg::SEQ_READ ||
                      state == flash_ctl_pkg::SEQ_POLL) && !cyc_done;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= flash_ctl_pkg::SEQ_IDLE;
      op <= 4'h0;
      step <= 3'h0;
      nsteps <= 3'h0;
      tgt_addr <= 16'h0000;
      tgt_data <= 16'h0000;
      wait_cnt <= 16'h0000;
    end else begin
      case (state)
        flash_ctl_pkg::SEQ_IDLE: begin
          if (i_wr && i_addr == `REG_ADDR) begin
            tgt_addr <= i_wdata;
          end
          if (i_wr && i_addr == `REG_DATA) begin
            tgt_data <= i_wdata;
          end
          if (i_wr && i_addr == `REG_CMD) begin
            op <= i_wdata[3:0];
            step <= 3'h0;
            case (i_wdata[3:0])
              `OP_READ: state <= flash_ctl_pkg::SEQ_READ;
              `OP_RESET: begin
                // single-cycle form, no unlock needed
                step <= 3'h2;
                nsteps <= 3'h3;
                state <= flash_ctl_pkg::SEQ_WRITE;
              end
              `OP_IDENT: begin
                nsteps <= 3'h3;
                state <= flash_ctl_pkg::SEQ_WRITE;
              end
              `OP_PROGRAM: begin
                nsteps <= 3'h4;
                state <= flash_ctl_pkg::SEQ_WRITE;
              end
              `OP_ERASE: begin
                nsteps <= 3'h6;
                state <= flash_ctl_pkg::SEQ_WRITE;
              end
              default: state <= flash_ctl_pkg::SEQ_IDLE;
            endcase
          end
        end
        flash_ctl_pkg::SEQ_WRITE: begin
          if (cyc_done) begin
            if (step + 3'h1 == nsteps) begin
              if (op == `OP_PROGRAM || op == `OP_ERASE) begin
                state <= flash_ctl_pkg::SEQ_POLL;
              end else if (op == `OP_IDENT) begin
                state <= flash_ctl_pkg::SEQ_READ;
              end else if (busy) begin
                // reset after a failed program or erase operation
                wait_cnt <= 16'(`RESET_WAIT_CYC);
                state <= flash_ctl_pkg::SEQ_WAIT;
              end else begin
                state <= flash_ctl_pkg::SEQ_FINISH;
              end
            end else begin
              step <= step + 3'h1;
            end
          end
        end
        flash_ctl_pkg::SEQ_READ: begin
          if (cyc_done) begin
            state <= flash_ctl_pkg::SEQ_FINISH;
          end
        end
        flash_ctl_pkg::SEQ_POLL: begin
          // done when two successive reads agree, or fail seen
          if (cyc_done && (done || failed)) begin
            state <= flash_ctl_pkg::SEQ_FINISH;
          end
        end
        flash_ctl_pkg::SEQ_WAIT: begin
          if (wait_cnt == 16'h0001) begin
            state <= flash_ctl_pkg::SEQ_FINISH;
          end
          wait_cnt <= wait_cnt - 16'h0001;
        end
        flash_ctl_pkg::SEQ_FINISH: state <= flash_ctl_pkg::SEQ_IDLE;
        default: state <= flash_ctl_pkg::SEQ_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // status interpretation
  // ------------------------------------------------------------
  // compare only the defined status bits, reserved ones masked
  logic [15:0] masked_now;
  logic [15:0] masked_last;
  assign masked_now = cyc_rdata & `ST_VALID_MASK;
  assign masked_last = last_read & `ST_VALID_MASK;
  assign done = (polls != 16'h0000) && (masked_now == masked_last) &&
                !cyc_rdata[`ST_FAIL_BIT];

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      last_read <= 16'h0000;
      polls <= 16'h0000;
      failed <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (state == flash_ctl_pkg::SEQ_IDLE && i_wr && i_addr == `REG_CMD) begin
        polls <= 16'h0000;
        if (i_wdata[3:0] == `OP_PROGRAM || i_wdata[3:0] == `OP_ERASE) begin
          failed <= 1'b0;
        end
      end
      if (state == flash_ctl_pkg::SEQ_POLL) begin
        busy <= 1'b1;
        if (cyc_done) begin
          last_read <= cyc_rdata;
          polls <= polls + 16'h0001;
          // bit 5 set with still-toggling data means the operation
          // failed; the only way out is a read/reset
          if (cyc_rdata[`ST_FAIL_BIT] && !done) begin
            failed <= 1'b1;
          end
        end
      end
      if (state == flash_ctl_pkg::SEQ_POLL && cyc_done && done) begin
        busy <= 1'b0;
      end
      if (state == flash_ctl_pkg::SEQ_WAIT && wait_cnt == 16'h0001) begin
        busy <= 1'b0;
        failed <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // software read port
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      result <= `REG_RDATA_RESET;
    end else if ((state == flash_ctl_pkg::SEQ_READ ||
                  state == flash_ctl_pkg::SEQ_POLL) && cyc_done) begin
      result <= cyc_rdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        `REG_CMD: o_rdata <= {12'h000, op};
        `REG_ADDR: o_rdata <= tgt_addr;
        `REG_DATA: o_rdata <= tgt_data;
        `REG_STATUS: o_rdata <= {13'h0, failed, busy,
                                 state != flash_ctl_pkg::SEQ_IDLE};
        `REG_RDATA: o_rdata <= result;
        `REG_POLLS: o_rdata <= polls;
        default: o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // outputs come from flops inside the cycle engine
  assign o_flash_addr = pins.addr;
  assign o_flash_dout = pins.dout;
  assign o_flash_dout_en = pins.dout_en;
  assign o_flash_ce_n = pins.ce_n;
  assign o_flash_oe_n = pins.oe_n;
  assign o_flash_we_n = pins.we_n;

endmodule // flash_command_status_unit

/* flash_command_status_unit_asserts.sv */
`timescale 1ns/10ps

module flash_command_status_unit_chk (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [15:0] o_flash_addr,
  input wire logic o_flash_dout_en,
  input wire logic o_flash_ce_n,
  input wire logic o_flash_oe_n,
  input wire logic o_flash_we_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // ------
  // pin cycle shape
  // ------
  sequence hold_tail;
    !o_flash_ce_n [*2] ##1 o_flash_ce_n;
  endsequence

  sequence strobe_pair(logic s);
    !s ##1 s;
  endsequence

  strobe_framed_a: assert property (
    (!o_flash_we_n || !o_flash_oe_n) |-> !o_flash_ce_n)
    else $error("strobe outside chip enable");
  one_strobe_a: assert property (o_flash_we_n || o_flash_oe_n)
    else $error("write and read strobe together");
  write_drives_a: assert property (!o_flash_we_n |-> o_flash_dout_en)
    else $error("write strobe without data drive");
  read_released_a: assert property (!o_flash_oe_n |-> !o_flash_dout_en)
    else $error("data driven during read strobe");
  we_pulse_a: assert property (
    $fell(o_flash_we_n) |=> strobe_pair(o_flash_we_n))
    else $error("write strobe not two cycles");
  oe_pulse_a: assert property (
    $fell(o_flash_oe_n) |=> strobe_pair(o_flash_oe_n))
    else $error("read strobe not two cycles");
  setup_lead_a: assert property (
    ($fell(o_flash_we_n) || $fell(o_flash_oe_n)) |->
      $past(o_flash_ce_n, 2) == 1'b0)
    else $error("strobe without two setup cycles");
  strobe_hold_a: assert property (
    ($rose(o_flash_we_n) || $rose(o_flash_oe_n)) |-> hold_tail)
    else $error("chip enable hold wrong");
  addr_held_a: assert property (
    (!o_flash_ce_n && !$past(o_flash_ce_n)) |-> $stable(o_flash_addr))
    else $error("address moved inside a cycle");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside answer cycle");
endmodule // flash_command_status_unit_chk

bind flash_command_status_unit flash_command_status_unit_chk i_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_flash_addr(o_flash_addr), .o_flash_dout_en(o_flash_dout_en),
  .o_flash_ce_n(o_flash_ce_n), .o_flash_oe_n(o_flash_oe_n),
  .o_flash_we_n(o_flash_we_n));

/* flash_dev_model.sv */
`timescale 1ns/10ps

module flash_dev_model #(
  parameter int PROG_CYC = 60,
  parameter int TIMER_CYC = 1000,
  parameter int ERASE_CYC = 200,
  parameter logic [15:0] MAKER_CODE = 16'h0037, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h005a // arbitrary value
) (
  input wire logic i_clk,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_dout,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  output logic [15:0] o_din,
  output logic o_seq_err
);
  // only 256 words stored; higher address bits alias
  logic [15:0] mem [0:255];
  logic [15:0] wa, pdata, last, rd_val;
  logic [7:0] operation_status;
  logic [2:0] step;
  logic ident, busy, erasing, fail, tog, we_q, oe_q, ok, armed;
  logic [10:0] a;
  logic [7:0] d;
  int cnt, gap;

  assign a = wa[10:0];
  assign d = i_dout[7:0];

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
    {wa, pdata, last, step, ident, busy, erasing, fail, tog} = '0;
    {we_q, oe_q, armed, o_seq_err} = 4'hc;
    cnt = 0;
    gap = 0;
  end

  // reserved bits toggle so a host that forgets the mask is caught
  always_comb begin
    operation_status = {8{tog}};
    operation_status[7] = erasing ? 1'b0 : ~pdata[7];
    operation_status[5] = fail;
    operation_status[3] = erasing ? (cnt <= ERASE_CYC) : 1'b1;
    operation_status[2] = erasing ? tog : 1'b1;
    if (busy) rd_val = {8'h00, operation_status};
    else if (ident) rd_val = i_addr[1] ? 16'h0000 :
      i_addr[0] ? PART_CODE : MAKER_CODE;
    else rd_val = mem[i_addr[7:0]];
  end

  // a released bus shows the inverse of the last word
  assign o_din = (!i_ce_n && !i_oe_n) ? rd_val : ~last;

  always @(posedge i_clk) begin
    we_q <= i_we_n;
    oe_q <= i_oe_n;
    gap <= gap + 1;
    if (!oe_q && i_oe_n) begin
      last <= rd_val;
      if (busy) tog <= ~tog;
    end
    if (busy && !fail) begin
      if (cnt == 0) begin
        busy <= 1'b0;
        erasing <= 1'b0;
        if (erasing) for (int i = 0; i < 256; i++) mem[i] <= 16'hffff;
      end else cnt <= cnt - 1;
    end
    if (we_q && !i_we_n) begin
      wa <= i_addr;
      if (armed && gap < 200) o_seq_err <= 1'b1;
      armed <= 1'b0;
    end
    if (!we_q && i_we_n && !i_ce_n) begin
      if (busy) begin
        if (fail && d == 8'hf0) begin
          busy <= 1'b0;
          fail <= 1'b0;
          armed <= 1'b1;
          gap <= 0;
        end
      end else begin
        case (step)
          3'd0: ok = d == 8'hf0 || (a == 11'h555 && d == 8'haa);
          3'd1, 3'd5: ok = a == 11'h2aa && d == 8'h55;
          3'd2: ok = a == 11'h555 && d inside {8'hf0, 8'h90, 8'ha0, 8'h80};
          3'd4: ok = a == 11'h555 && d == 8'haa;
          3'd6: ok = a == 11'h555 && d == 8'h10;
          default: ok = 1'b1;
        endcase
        if (!ok) begin
          step <= 3'd0;
          ident <= 1'b0;
          o_seq_err <= 1'b1;
        end else case (step)
          3'd0: if (d == 8'hf0) ident <= 1'b0; else step <= 3'd1;
          3'd2: begin
            ident <= d == 8'h90;
            step <= d == 8'ha0 ? 3'd3 : d == 8'h80 ? 3'd4 : 3'd0;
          end
          3'd3: begin
            fail <= |(i_dout & ~mem[wa[7:0]]);
            mem[wa[7:0]] <= mem[wa[7:0]] & i_dout;
            pdata <= i_dout;
            busy <= 1'b1;
            cnt <= PROG_CYC;
            step <= 3'd0;
          end
          3'd6: begin
            for (int i = 0; i < 256; i++) mem[i] <= 16'h0000;
            busy <= 1'b1;
            erasing <= 1'b1;
            cnt <= TIMER_CYC + ERASE_CYC;
            step <= 3'd0;
          end
          default: step <= step + 3'd1;
        endcase
      end
    end
  end
endmodule // flash_dev_model

/* flash_command_status_unit_tb.sv */
`timescale 1ns/10ps
`include "flash_ctl_defs.svh"

module flash_command_status_unit_tb;
  localparam logic [15:0] MAKER = 16'h0037; // arbitrary value
  localparam logic [15:0] PART = 16'h005a; // arbitrary value
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic [15:0] o_rdata, din, f_addr, f_dout, rv;
  logic f_den, f_ce_n, f_oe_n, f_we_n, seq_err;
  int n_fail = 0;
  int checks = 0;

  always #25 i_clk = ~i_clk;

  flash_command_status_unit i_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_flash_din(din), .o_flash_addr(f_addr), .o_flash_dout(f_dout),
    .o_flash_dout_en(f_den), .o_flash_ce_n(f_ce_n),
    .o_flash_oe_n(f_oe_n), .o_flash_we_n(f_we_n));

  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_flash (
    .i_clk(i_clk), .i_addr(f_addr), .i_dout(f_dout), .i_ce_n(f_ce_n),
    .i_oe_n(f_oe_n), .i_we_n(f_we_n), .o_din(din), .o_seq_err(seq_err));

  // ------
  // bus and report tasks
  // ------
  task close_out;
    $display("counts: %0d checks, %0d failures", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // a poll must not return before the op has started, so status bit 0 (sequencer active) must be seen set first
  task run_op(input logic [3:0] op, input logic [15:0] a,
              input logic [15:0] d);
    bit seen;
    seen = 1'b0;
    reg_wr(`REG_ADDR, a);
    reg_wr(`REG_DATA, d);
    reg_wr(`REG_CMD, {12'h000, op});
    for (int i = 0; i < 4000; i++) begin
      reg_rd(`REG_STATUS, rv);
      if (rv[0] === 1'b1) seen = 1'b1;
      else if (seen) return;
    end
    $display("CHECK FAILED at %0t: operation did not finish", $time);
    n_fail++;
    close_out();
  endtask

  // ------
  // scenarios
  // ------
  task t_reset;
    chk({12'h000, f_ce_n, f_oe_n, f_we_n, f_den}, 16'h000e);
    reg_rd(`REG_RDATA, rv);
    chk(rv, `REG_RDATA_RESET);
    reg_wr(4'hf, 16'hffff);
    reg_rd(`REG_STATUS, rv);
    chk(rv & 16'h0007, 16'h0000);
    $display("test reset done");
  endtask

  task t_program;
    run_op(`OP_PROGRAM, 16'h0012, 16'h3c14);
    reg_rd(`REG_STATUS, rv);
    chk(rv & 16'h0007, 16'h0000);
    reg_rd(`REG_POLLS, rv);
    chk(16'(rv > 16'h0003), 16'h0001);
    reg_rd(`REG_CMD, rv);
    chk(rv, {12'h000, `OP_PROGRAM});
    reg_rd(`REG_ADDR, rv);
    chk(rv, 16'h0012);
    run_op(`OP_READ, 16'h0012, 16'h0000);
    reg_rd(`REG_RDATA, rv);
    chk(rv, 16'h3c14);
    $display("test program done");
  endtask

  task t_fail;
    run_op(`OP_PROGRAM, 16'h0012, 16'hffff);
    reg_rd(`REG_STATUS, rv);
    chk(rv & 16'h0006, 16'h0006);
    reg_rd(`REG_RDATA, rv);
    chk(rv & 16'h0020, 16'h0020);
    run_op(`OP_RESET, 16'h0000, 16'h0000);
    reg_rd(`REG_STATUS, rv);
    chk(rv & 16'h0002, 16'h0000);
    run_op(`OP_READ, 16'h0012, 16'h0000);
    reg_rd(`REG_RDATA, rv);
    chk(rv, 16'h3c14);
    $display("test failed program done");
  endtask

  task t_erase;
    run_op(`OP_ERASE, 16'h0000, 16'h0000);
    reg_rd(`REG_RDATA, rv);
    chk(rv & `ST_VALID_MASK, `ST_VALID_MASK);
    reg_rd(`REG_POLLS, rv);
    chk(16'(rv > 16'h0063), 16'h0001);
    run_op(`OP_READ, 16'h0012, 16'h0000);
    reg_rd(`REG_RDATA, rv);
    chk(rv, 16'hffff);
    $display("test erase done");
  endtask

  task t_ident;
    run_op(`OP_IDENT, 16'h0000, 16'h0000);
    reg_rd(`REG_RDATA, rv);
    chk(rv, MAKER);
    run_op(`OP_IDENT, 16'h0001, 16'h0000);
    reg_rd(`REG_RDATA, rv);
    chk(rv, PART);
    $display("test identify done");
  endtask

  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_reset();
    t_program();
    t_fail();
    t_erase();
    t_ident();
    chk({15'h0, seq_err}, 16'h0000);
    close_out();
  end
endmodule // flash_command_status_unit_tb
